// *** verilog/scfg_defines.svh ***
// indexes, reset values, bit positions and decode ranges
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

// config keys at the index port
`define SCFG_KEY_ENTER      8'h44
`define SCFG_KEY_EXIT       8'haa

// config ports, full 16-bit isa addresses
`define SCFG_INDEX_PORT     16'h03f0
`define SCFG_DATA_PORT      16'h03f1

// register indexes
`define SCFG_IDX_OPTIONS    8'h05
`define SCFG_IDX_DRIVE_TYPE 8'h06
`define SCFG_IDX_BOOT_MEDIA 8'h07
`define SCFG_IDX_DEC_LOW    8'h08
`define SCFG_IDX_DEC_HIGH   8'h09
`define SCFG_IDX_THRESHOLD  8'h0a
`define SCFG_IDX_RSVD_B     8'h0b
`define SCFG_IDX_RSVD_C     8'h0c
`define SCFG_IDX_DEVICE_ID  8'h0d
`define SCFG_IDX_REVISION   8'h0e
`define SCFG_IDX_TEST       8'h0f

// power-up values
`define SCFG_RST_OPTIONS    8'h00
`define SCFG_RST_DRIVE_TYPE 8'hff
`define SCFG_RST_BOOT_MEDIA 8'h00
`define SCFG_RST_DEC_LOW    8'h00
`define SCFG_RST_DEC_HIGH   8'h00
`define SCFG_RST_THRESHOLD  8'h00
`define SCFG_RST_TEST       8'h00
`define SCFG_RSVD_READ      8'h00

// bit positions inside address_and_drive_options
`define SCFG_OPT_FDC_SEC    0
`define SCFG_OPT_IDE_SEC    1
`define SCFG_OPT_NONBURST   2
`define SCFG_OPT_DENS_LO    3
`define SCFG_OPT_DENS_HI    4
`define SCFG_OPT_SWAP       5
`define SCFG_OPT_EXT4       6
`define SCFG_OPT_DS3        7

// decode ranges, compared on address bits 15:3 or 15:1
`define SCFG_FDC_PRI_BASE   16'h03f0
`define SCFG_FDC_SEC_BASE   16'h0370
`define SCFG_IDE_PRI_BASE   16'h01f0
`define SCFG_IDE_SEC_BASE   16'h0170
`define SCFG_IDE_PRI_ALT    16'h03f6
`define SCFG_IDE_SEC_ALT    16'h0376

`endif

// *** verilog/scfg_pkg.sv ***
// types shared by the config register bank
package scfg_pkg;

    // config mode sequencer
    typedef enum logic [1:0] {
        SCFG_IDLE   = 2'b00,   // normal operation
        SCFG_KEY1   = 2'b01,   // first key seen
        SCFG_ACTIVE = 2'b10    // config mode open
    } scfg_mode_e;

    // whole state of the bank
    typedef struct packed {
        scfg_mode_e  mode;
        logic        iow_n_d;     // previous synced write strobe
        logic        ior_n_d;     // previous synced read strobe
        logic [7:0]  index;
        logic [7:0]  options;
        logic [7:0]  drive_type;
        logic [7:0]  boot_media;
        logic [7:0]  dec_low;
        logic [7:0]  dec_high;
        logic [7:0]  threshold;
        logic [7:0]  test;
        logic [7:0]  rd_data;
        logic        rd_oe;
        logic        fdc_cs;
        logic        ide_cs0;
        logic        ide_cs1;
        logic        gen_strobe;
        logic        drq;
        logic        irq;
        logic        density;
        logic [1:0]  drive_sel;
        logic        shared_pin;
        logic [3:0]  motor;
    } scfg_state_s;

endpackage : scfg_pkg

// *** verilog/scfg_sync.sv ***
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module scfg_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_value_in,
    output logic      [WIDTH-1:0] sync_out
);
    // both stages in one struct
    typedef struct packed {
        logic [WIDTH-1:0] meta;   // first stage, read only by second
        logic [WIDTH-1:0] sync;   // second stage
    } scfg_sync_s;

    scfg_sync_s st;
    scfg_sync_s next_st;
    logic [1:0]       idle_q;     // idle window shift

    // per-bit two flip-flop chain
    always_comb begin
        next_st.meta = async_in;
        next_st.sync = st.meta;
    end

    // stage flops clear to zero
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // two-edge idle window, else zeroed stages look like a false edge
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_q <= 2'b11;
        end else begin
            idle_q <= {idle_q[0], 1'b0};
        end
    end

    // until the chain fills, show the given idle value
    assign sync_out = idle_q[1] ? reset_value_in : st.sync;
endmodule : scfg_sync

// *** verilog/scfg_top.sv ***
// indexed config register bank with isa decode and floppy options
// Operation
// - registers reachable only in config mode by index
// - two 44h writes enter, aah write exits
// - option bit 0 moves floppy to secondary range
// - option bit 1 moves ide to secondary range
// - option bit 2 gives per-byte request strobes
// - option bit 5 swaps drive and motor 0/1
// - option bit 6 gives encoded external drive selects
// - option bit 7 picks shared pin function
// - index 06h drive types, resets to ffh
// - index 07h boot drive and media polarity
// - index 08h decoder low bits, aen qualified
// - index 09h decoder high bits, a10 gated
// - index 0ah ecp fifo threshold, resets zero
// - indexes 0bh, 0ch reserved, read as 00h
// - index 0dh read-only device code
// - index 0eh read-only revision code
// - index 0fh test bits, reset zero
`timescale 1ns/1ps
`include "scfg_defines.svh"
module scfg_top #(
    parameter logic [7:0] DEVICE_CODE   = 8'h5a,  // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h01   // arbitrary value
) (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // isa host pins
    input  wire logic [15:0] isa_addr_in,
    input  wire logic [7:0]  isa_data_in,
    input  wire logic        isa_iow_n_in,
    input  wire logic        isa_ior_n_in,
    input  wire logic        isa_aen_in,
    output logic      [7:0]  isa_data_out,
    output logic             isa_data_oe_out,
    // chip selects
    output logic             floppy_controller_cs_out,
    output logic             ide_cs0_out,
    output logic             ide_cs1_out,
    output logic             general_decode_strobe_out,
    // parallel port status, same clock
    input  wire logic        ecp_mode_in,
    input  wire logic        parallel_direction_in,
    // floppy core side, same clock
    input  wire logic        fdc_drq_in,
    input  wire logic        fdc_irq_in,
    input  wire logic        fdc_fifo_en_in,
    input  wire logic        fdc_byte_done_in,
    input  wire logic        fdc_density_in,
    input  wire logic [3:0]  fdc_drive_sel_in,
    input  wire logic [3:0]  fdc_motor_in,
    // floppy pins
    output logic             floppy_dma_request_out,
    output logic             floppy_interrupt_request_out,
    output logic             density_select_out,
    output logic [1:0]       drive_select_out,
    output logic             parallel_direction_out,
    output logic [3:0]       motor_select_out,
    // register contents for the other functions
    output logic [7:0]       drive_type_setup_out,
    output logic [7:0]       boot_drive_media_polarity_out,
    output logic [7:0]       ecp_fifo_threshold_out,
    output logic [7:0]       test_control_out
);
    import scfg_pkg::*;

    localparam int SYNC_W = 27;   // addr, data, iow, ior, aen

    scfg_state_s st;              // registered state
    scfg_state_s next_st;         // next value

    logic [SYNC_W-1:0] pin_raw;   // raw pin bundle
    logic [SYNC_W-1:0] pin_idle;  // idle pin levels
    logic [SYNC_W-1:0] pin_sync;  // synced bundle
    logic [15:0] addr;            // synced address
    logic [7:0]  wdata;           // synced write data
    logic        iow_n;           // synced write strobe
    logic        ior_n;           // synced read strobe
    logic        aen;             // synced address enable

    // all host pins cross into the clock domain
    assign pin_raw  = {isa_addr_in, isa_data_in, isa_iow_n_in, isa_ior_n_in, isa_aen_in};
    assign pin_idle = {16'h0000, 8'h00, 1'b1, 1'b1, 1'b1};

    scfg_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock_in       (clock_in),
        .rst_n_in       (rst_n_in),
        .async_in       (pin_raw),
        .reset_value_in (pin_idle),
        .sync_out       (pin_sync)
    );

    assign addr  = pin_sync[26:11];
    assign wdata = pin_sync[10:3];
    assign iow_n = pin_sync[2];
    assign ior_n = pin_sync[1];
    assign aen   = pin_sync[0];

    // combinational helpers
    logic        wr_evt;          // falling edge of write strobe
    logic        rd_evt;          // falling edge of read strobe
    logic        io_cycle;        // host i/o cycle, dma excluded
    logic        at_index;        // index port addressed
    logic        at_data;         // data port addressed
    logic [15:0] fdc_base;        // active floppy base
    logic [15:0] ide_base;        // active ide base
    logic [15:0] ide_alt;         // active ide alternate pair
    logic [10:0] gen_addr;        // decoder compare address
    logic [7:0]  rd_mux;          // value read at current index
    logic [3:0]  sel_sw;          // drive selects after swap
    logic [3:0]  mot_sw;          // motors after swap
    logic [1:0]  sel_enc;         // encoded drive number
    logic        sel_any;         // some drive selected
    logic        no_strobe;       // suppress request this cycle

    // register read mux
    always_comb begin
        case (st.index)
            `SCFG_IDX_OPTIONS:    rd_mux = st.options;
            `SCFG_IDX_DRIVE_TYPE: rd_mux = st.drive_type;
            `SCFG_IDX_BOOT_MEDIA: rd_mux = st.boot_media;
            `SCFG_IDX_DEC_LOW:    rd_mux = st.dec_low;
            `SCFG_IDX_DEC_HIGH:   rd_mux = st.dec_high;
            `SCFG_IDX_THRESHOLD:  rd_mux = st.threshold;
            `SCFG_IDX_RSVD_B:     rd_mux = `SCFG_RSVD_READ;
            `SCFG_IDX_RSVD_C:     rd_mux = `SCFG_RSVD_READ;
            `SCFG_IDX_DEVICE_ID:  rd_mux = DEVICE_CODE;
            `SCFG_IDX_REVISION:   rd_mux = REVISION_CODE;
            `SCFG_IDX_TEST:       rd_mux = st.test;
            default:              rd_mux = 8'h00;             // unmapped index
        endcase
    end

    // next state of the bank
    always_comb begin
        next_st = st;
        next_st.iow_n_d = iow_n;
        next_st.ior_n_d = ior_n;
        io_cycle = !aen;
        wr_evt   = st.iow_n_d && !iow_n && io_cycle;
        rd_evt   = st.ior_n_d && !ior_n && io_cycle;
        at_index = (addr == `SCFG_INDEX_PORT);
        at_data  = (addr == `SCFG_DATA_PORT);

        // key sequence; any access between breaks it
        case (st.mode)
            SCFG_IDLE: begin
                if (wr_evt && at_index && wdata == `SCFG_KEY_ENTER) begin
                    next_st.mode = SCFG_KEY1;
                end
            end
            SCFG_KEY1: begin
                if (wr_evt && at_index && wdata == `SCFG_KEY_ENTER) begin
                    next_st.mode = SCFG_ACTIVE;
                end else if (wr_evt || rd_evt) begin
                    next_st.mode = SCFG_IDLE;
                end
            end
            SCFG_ACTIVE: begin
                if (wr_evt && at_index) begin
                    if (wdata == `SCFG_KEY_EXIT) begin
                        next_st.mode = SCFG_IDLE;
                    end else begin
                        next_st.index = wdata;
                    end
                end else if (wr_evt && at_data) begin
                    // writes land at current index
                    case (st.index)
                        `SCFG_IDX_OPTIONS:    next_st.options    = wdata;
                        `SCFG_IDX_DRIVE_TYPE: next_st.drive_type = wdata;
                        `SCFG_IDX_BOOT_MEDIA: next_st.boot_media = wdata;
                        `SCFG_IDX_DEC_LOW:    next_st.dec_low    = wdata;
                        `SCFG_IDX_DEC_HIGH:   next_st.dec_high   = wdata;
                        `SCFG_IDX_THRESHOLD:  next_st.threshold  = wdata;
                        `SCFG_IDX_TEST:       next_st.test       = wdata;
                        default: begin
                            // read-only and reserved ignore writes
                            next_st.index = st.index;
                        end
                    endcase
                end
            end
            default: begin
                next_st.mode = SCFG_IDLE;
            end
        endcase

        // data port read in config mode
        if (st.mode == SCFG_ACTIVE && at_data && !ior_n && io_cycle) begin
            next_st.rd_data = rd_mux;
            next_st.rd_oe   = 1'b1;
        end else begin
            next_st.rd_data = 8'h00;
            next_st.rd_oe   = 1'b0;
        end

        // chip selects, qualified by aen low
        fdc_base = st.options[`SCFG_OPT_FDC_SEC] ? `SCFG_FDC_SEC_BASE
                                                 : `SCFG_FDC_PRI_BASE;
        ide_base = st.options[`SCFG_OPT_IDE_SEC] ? `SCFG_IDE_SEC_BASE
                                                 : `SCFG_IDE_PRI_BASE;
        ide_alt  = st.options[`SCFG_OPT_IDE_SEC] ? `SCFG_IDE_SEC_ALT
                                                 : `SCFG_IDE_PRI_ALT;
        // config ports hidden from floppy while open
        next_st.fdc_cs  = io_cycle && (addr[15:3] == fdc_base[15:3]) &&
                          !(st.mode == SCFG_ACTIVE && (at_index || at_data));
        next_st.ide_cs0 = io_cycle && (addr[15:3] == ide_base[15:3]);
        next_st.ide_cs1 = io_cycle && (addr[15:1] == ide_alt[15:1]);

        // general decoder; a10 low outside ecp
        gen_addr = {addr[10] && ecp_mode_in, addr[9:0]};
        next_st.gen_strobe = io_cycle &&
                             (gen_addr == {st.dec_high[2:0], st.dec_low});

        // non-burst: drop request one cycle per byte
        no_strobe = st.options[`SCFG_OPT_NONBURST] && fdc_fifo_en_in &&
                    fdc_byte_done_in;
        next_st.drq = fdc_drq_in && !no_strobe;
        next_st.irq = fdc_irq_in && !no_strobe;

        // density override; reserved code passes through
        case ({st.options[`SCFG_OPT_DENS_HI], st.options[`SCFG_OPT_DENS_LO]})
            2'b10:   next_st.density = 1'b1;
            2'b11:   next_st.density = 1'b0;
            default: next_st.density = fdc_density_in;
        endcase

        // drive and motor swap of units 0 and 1
        if (st.options[`SCFG_OPT_SWAP]) begin
            sel_sw = {fdc_drive_sel_in[3:2], fdc_drive_sel_in[0], fdc_drive_sel_in[1]};
            mot_sw = {fdc_motor_in[3:2], fdc_motor_in[0], fdc_motor_in[1]};
        end else begin
            sel_sw = fdc_drive_sel_in;
            mot_sw = fdc_motor_in;
        end
        next_st.motor = mot_sw;

        // encode one-hot select for external decoder
        sel_any = |sel_sw;
        sel_enc = {sel_sw[3] || sel_sw[2], sel_sw[3] || sel_sw[1]};
        if (st.options[`SCFG_OPT_EXT4]) begin
            next_st.drive_sel = sel_enc;
        end else begin
            next_st.drive_sel = sel_sw[1:0];
        end

        // shared pin: third or fourth select, parallel direction, or in encoded mode any drive selected or low
        if (st.options[`SCFG_OPT_DS3]) begin
            next_st.shared_pin = st.options[`SCFG_OPT_EXT4] ? 1'b0 : sel_sw[3];
        end else if (ecp_mode_in) begin
            next_st.shared_pin = parallel_direction_in;
        end else begin
            // encoded mode: any drive selected
            next_st.shared_pin = st.options[`SCFG_OPT_EXT4] ? sel_any : sel_sw[2];
        end
    end

    // single state register with power-up values
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st            <= '0;
            st.mode       <= SCFG_IDLE;
            st.iow_n_d    <= 1'b1;
            st.ior_n_d    <= 1'b1;
            st.options    <= `SCFG_RST_OPTIONS;
            st.drive_type <= `SCFG_RST_DRIVE_TYPE;
            st.boot_media <= `SCFG_RST_BOOT_MEDIA;
            st.dec_low    <= `SCFG_RST_DEC_LOW;
            st.dec_high   <= `SCFG_RST_DEC_HIGH;
            st.threshold  <= `SCFG_RST_THRESHOLD;
            st.test       <= `SCFG_RST_TEST;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign isa_data_out                  = st.rd_data;
    assign isa_data_oe_out               = st.rd_oe;
    assign floppy_controller_cs_out      = st.fdc_cs;
    assign ide_cs0_out                   = st.ide_cs0;
    assign ide_cs1_out                   = st.ide_cs1;
    assign general_decode_strobe_out     = st.gen_strobe;
    assign floppy_dma_request_out        = st.drq;
    assign floppy_interrupt_request_out  = st.irq;
    assign density_select_out            = st.density;
    assign drive_select_out              = st.drive_sel;
    assign parallel_direction_out        = st.shared_pin;
    assign motor_select_out              = st.motor;
    assign drive_type_setup_out          = st.drive_type;
    assign boot_drive_media_polarity_out = st.boot_media;
    assign ecp_fifo_threshold_out        = st.threshold;
    assign test_control_out              = st.test;
endmodule : scfg_top

// *** tb/scfg_chk.sv ***
// concurrent checks on the config register bank ports
`timescale 1ns/1ps
module scfg_chk (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic [15:0] isa_addr_in,
    input  wire logic        isa_iow_n_in,
    input  wire logic        isa_ior_n_in,
    input  wire logic        isa_aen_in,
    input  wire logic [7:0]  isa_data_out,
    input  wire logic        isa_data_oe_out,
    input  wire logic        floppy_controller_cs_out,
    input  wire logic        ide_cs0_out,
    input  wire logic        ide_cs1_out,
    input  wire logic        general_decode_strobe_out,
    input  wire logic        fdc_drq_in,
    input  wire logic        fdc_irq_in,
    input  wire logic [3:0]  fdc_motor_in,
    input  wire logic        floppy_dma_request_out,
    input  wire logic        floppy_interrupt_request_out,
    input  wire logic [3:0]  motor_select_out,
    input  wire logic [7:0]  drive_type_setup_out,
    input  wire logic [7:0]  boot_drive_media_polarity_out,
    input  wire logic [7:0]  ecp_fifo_threshold_out,
    input  wire logic [7:0]  test_control_out
);
    // one clock domain
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    bus_quiet_a: assert property (!isa_data_oe_out |-> isa_data_out == 8'h00)
        else $error("data without enable");
    read_cause_a: assert property ($rose(isa_data_oe_out) |-> !$past(isa_ior_n_in, 2))
        else $error("enable without read");
    read_drop_a: assert property (isa_ior_n_in [*6] |-> !isa_data_oe_out)
        else $error("enable held after read");
    dtype_reset_a: assert property ($rose(rst_n_in) |-> drive_type_setup_out == 8'hff)
        else $error("drive type not ff at reset");
    // registers move only under a write strobe
    reg_write_a: assert property (!$stable({drive_type_setup_out, boot_drive_media_polarity_out,
        ecp_fifo_threshold_out, test_control_out}) |-> !$past(isa_iow_n_in, 2))
        else $error("register moved without write");
    aen_block_a: assert property (isa_aen_in [*4] |-> !(floppy_controller_cs_out ||
        ide_cs0_out || ide_cs1_out || general_decode_strobe_out))
        else $error("decode during dma cycle");
    fdc_range_a: assert property (floppy_controller_cs_out |->
        $past(isa_addr_in[15:3], 3) inside {13'h007e, 13'h006e})
        else $error("floppy select off range");
    ide_range_a: assert property (ide_cs0_out |->
        $past(isa_addr_in[15:3], 3) inside {13'h003e, 13'h002e})
        else $error("ide select off range");
    ide_alt_a: assert property (ide_cs1_out |->
        $past(isa_addr_in[15:1], 3) inside {15'h01fb, 15'h01bb})
        else $error("ide alt select off range");
    dma_follow_a: assert property (floppy_dma_request_out |-> $past(fdc_drq_in))
        else $error("dma request unprompted");
    irq_follow_a: assert property (floppy_interrupt_request_out |-> $past(fdc_irq_in))
        else $error("interrupt unprompted");
    // swap reorders motors, never adds one
    motor_count_a: assert property ($past(rst_n_in) |->
        $countones(motor_select_out) == $countones($past(fdc_motor_in)))
        else $error("motor count differs");
endmodule : scfg_chk

bind scfg_top scfg_chk chk (.*);

// *** tb/scfg_host.sv ***
// isa host model issuing i/o cycles to the config bank
`timescale 1ns/1ps
module scfg_host (
    input  wire logic        clock_in,
    input  wire logic [7:0]  rd_data_in,
    input  wire logic        rd_oe_in,
    output logic      [15:0] addr_out,
    output logic      [7:0]  data_out,
    output logic             iow_n_out,
    output logic             ior_n_out,
    output logic             aen_out
);
    // idle bus, aen high
    initial begin
        addr_out = 16'h0000;
        data_out = 8'h00;
        iow_n_out = 1'b1;
        ior_n_out = 1'b1;
        aen_out = 1'b1;
    end

    // park an address, no strobe
    task automatic show(input logic [15:0] a, input logic e);
        @(posedge clock_in) addr_out <= a;
        aen_out <= e;
    endtask : show

    // one byte cycle, address and data held throughout
    task automatic io_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                            output logic [7:0] q, output logic seen);
        seen = 1'b0;
        q = 8'h00;
        @(posedge clock_in) addr_out <= a;
        aen_out <= 1'b0;
        data_out <= wr ? d : ~data_out;
        @(posedge clock_in) if (wr) iow_n_out <= 1'b0; else ior_n_out <= 1'b0;
        repeat (6) begin
            @(posedge clock_in);
            if (rd_oe_in === 1'b1) begin
                seen = 1'b1;
                q = rd_data_in;
            end
        end
        iow_n_out <= 1'b1;
        ior_n_out <= 1'b1;
        data_out <= ~d;      // released bus shows the inverse
        repeat (6) @(posedge clock_in);
    endtask : io_cycle
endmodule : scfg_host

// *** tb/test_superio_config_registers.sv ***
// directed testbench for the config register bank
`timescale 1ns/1ps
`include "scfg_defines.svh"
`define SCFG_CMP(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module test_superio_config_registers;
    localparam logic [7:0] DEV_CODE = 8'h5a;   // arbitrary value
    localparam logic [7:0] REV_CODE = 8'h01;   // arbitrary value
    logic        clock_in = 1'b0, rst_n_in = 1'b0;
    logic [15:0] isa_addr_in;
    logic [7:0]  isa_data_in, isa_data_out, drive_type_setup_out, boot_drive_media_polarity_out;
    logic [7:0]  ecp_fifo_threshold_out, test_control_out, q;
    logic        isa_iow_n_in, isa_ior_n_in, isa_aen_in, isa_data_oe_out, s;
    logic        floppy_controller_cs_out, ide_cs0_out, ide_cs1_out, general_decode_strobe_out;
    logic        ecp_mode_in = 1'b0, parallel_direction_in = 1'b0;
    logic        fdc_drq_in = 1'b0, fdc_irq_in = 1'b0, fdc_fifo_en_in = 1'b0;
    logic        fdc_byte_done_in = 1'b0, fdc_density_in = 1'b0;
    logic [3:0]  fdc_drive_sel_in = 4'h0, fdc_motor_in = 4'h0, motor_select_out;
    logic        floppy_dma_request_out, floppy_interrupt_request_out, density_select_out;
    logic        parallel_direction_out;
    logic [1:0]  drive_select_out;
    int          failures = 0, checked = 0, lows;
    // index, written byte, expected read-back
    logic [7:0]  ridx [10] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0f, 8'h0d, 8'h0e, 8'h0b, 8'h10};
    logic [7:0]  rwr [10]  = '{8'h12, 8'h5c, 8'h34, 8'h02, 8'h9e, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
    logic [7:0]  rexp [10] = '{8'h12, 8'h5c, 8'h34, 8'h02, 8'h9e, 8'h00, DEV_CODE, REV_CODE,
                               8'h00, 8'h00};
    logic [15:0] caddr [2][4] = '{'{16'h03f4, 16'h0374, 16'h01f2, 16'h03f6},
                                 '{16'h0374, 16'h03f4, 16'h0172, 16'h0376}};
    logic [2:0]  cexp [4] = '{3'b100, 3'b000, 3'b010, 3'b101};
    logic [7:0]  dopt [3] = '{8'h00, 8'h10, 8'h18};

    scfg_top #(.DEVICE_CODE(DEV_CODE), .REVISION_CODE(REV_CODE)) dut (.*);
    scfg_host host (.clock_in(clock_in), .rd_data_in(isa_data_out), .rd_oe_in(isa_data_oe_out),
        .addr_out(isa_addr_in), .data_out(isa_data_in), .iow_n_out(isa_iow_n_in),
        .ior_n_out(isa_ior_n_in), .aen_out(isa_aen_in));

    // 125 mhz clock
    always #4 clock_in = ~clock_in;

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host.io_cycle(1'b1, a, d, q, s);
    endtask : wr
    task automatic rd(input logic [15:0] a);
        host.io_cycle(1'b0, a, 8'h00, q, s);
    endtask : rd
    // index first, then data
    task automatic set_reg(input logic [7:0] i, input logic [7:0] d);
        wr(`SCFG_INDEX_PORT, i);
        wr(`SCFG_DATA_PORT, d);
    endtask : set_reg
    task automatic look(input logic [15:0] a, input logic e);
        host.show(a, e);
        repeat (5) @(posedge clock_in);
    endtask : look
    task automatic tick;
        repeat (3) @(posedge clock_in);
    endtask : tick

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // watchdog, far beyond the expected run
    initial begin
        #400000;
        failures++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        `SCFG_CMP(drive_type_setup_out, `SCFG_RST_DRIVE_TYPE)
        `SCFG_CMP({boot_drive_media_polarity_out, ecp_fifo_threshold_out, test_control_out}, 24'h0)
        rd(`SCFG_DATA_PORT);
        `SCFG_CMP(s, 1'b0)
        // foreign access between keys spoils entry
        wr(`SCFG_INDEX_PORT, `SCFG_KEY_ENTER);
        rd(16'h03f4);
        wr(`SCFG_INDEX_PORT, `SCFG_KEY_ENTER);
        rd(`SCFG_DATA_PORT);
        `SCFG_CMP(s, 1'b0)
        wr(`SCFG_INDEX_PORT, `SCFG_KEY_ENTER);
        wr(`SCFG_INDEX_PORT, `SCFG_KEY_ENTER);
        for (int i = 0; i < 10; i++) begin
            set_reg(ridx[i], rwr[i]);
            rd(`SCFG_DATA_PORT);
            `SCFG_CMP({s, q}, {1'b1, rexp[i]})
        end
        // decoder compare value is now 0x234
        look(16'h0234, 1'b1);
        `SCFG_CMP(general_decode_strobe_out, 1'b0)
        look(16'h0234, 1'b0);
        `SCFG_CMP(general_decode_strobe_out, 1'b1)
        look(16'h0634, 1'b0);
        `SCFG_CMP(general_decode_strobe_out, 1'b1)
        ecp_mode_in <= 1'b1;
        look(16'h0634, 1'b0);
        `SCFG_CMP(general_decode_strobe_out, 1'b0)
        ecp_mode_in <= 1'b0;
        for (int o = 0; o < 2; o++) begin
            set_reg(`SCFG_IDX_OPTIONS, o ? 8'h03 : 8'h00);
            for (int j = 0; j < 4; j++) begin
                look(caddr[o][j], 1'b0);
                `SCFG_CMP({floppy_controller_cs_out, ide_cs0_out, ide_cs1_out}, cexp[j])
            end
        end
        for (int k = 0; k < 3; k++) begin
            set_reg(`SCFG_IDX_OPTIONS, dopt[k]);
            fdc_density_in <= (k == 2);
            tick();
            `SCFG_CMP(density_select_out, k == 1)
        end
        set_reg(`SCFG_IDX_OPTIONS, 8'h20);
        fdc_motor_in <= 4'b0001;
        tick();
        `SCFG_CMP(motor_select_out, 4'b0010)
        set_reg(`SCFG_IDX_OPTIONS, 8'h40);
        fdc_drive_sel_in <= 4'b1000;
        tick();
        `SCFG_CMP(drive_select_out, 2'b11)
        fdc_drive_sel_in <= 4'b0100;
        tick();
        `SCFG_CMP(drive_select_out, 2'b10)
        // shared pin in three of its roles
        set_reg(`SCFG_IDX_OPTIONS, 8'h00);
        tick();
        `SCFG_CMP(parallel_direction_out, 1'b1)
        ecp_mode_in <= 1'b1;
        parallel_direction_in <= 1'b1;
        fdc_drive_sel_in <= 4'b1000;
        tick();
        `SCFG_CMP(parallel_direction_out, 1'b1)
        parallel_direction_in <= 1'b0;
        tick();
        `SCFG_CMP(parallel_direction_out, 1'b0)
        set_reg(`SCFG_IDX_OPTIONS, 8'h80);
        tick();
        `SCFG_CMP(parallel_direction_out, 1'b1)
        // non-burst drops requests one cycle per byte
        for (int m = 0; m < 2; m++) begin
            set_reg(`SCFG_IDX_OPTIONS, m ? 8'h04 : 8'h00);
            fdc_fifo_en_in <= 1'b1;
            fdc_drq_in <= 1'b1;
            fdc_irq_in <= 1'b1;
            repeat (4) @(posedge clock_in);
            fdc_byte_done_in <= 1'b1;
            @(posedge clock_in) fdc_byte_done_in <= 1'b0;
            lows = 0;
            repeat (6) begin
                @(posedge clock_in);
                lows += int'(floppy_dma_request_out === 1'b0);
                lows += int'(floppy_interrupt_request_out === 1'b0);
            end
            `SCFG_CMP(lows, m * 2)
        end
        wr(`SCFG_INDEX_PORT, `SCFG_KEY_EXIT);
        rd(`SCFG_DATA_PORT);
        `SCFG_CMP(s, 1'b0)
        give_verdict();
    end
endmodule : test_superio_config_registers
